// *** hw/led_brightness_code_mapper.sv ***
// What this block does
// - Config bit 7 is simple enable
// - Bit 6 zero means positive PWM polarity
// - Bit 5 scales current by PWM duty
// - Bits 4:2 pick full-scale current
// - Bit 1 picks exponential or linear table
// - Bit 0 enables the device
// - PWM disabled ignores input duty cycle
// - Serial mode: full scale times mapped percentage
// - Mapping bit switches linear versus exponential curve
// - Exponential lookup starts 0, 0.080 percent, monotonic
// - Exponential code 0x72 gives 48.438 percent
// - Linear code 0x72 gives 89.76 percent
// - Polarity one uses low-time duty
`timescale 1ns/1ns
`default_nettype none
module led_brightness_code_mapper #(
   parameter int WIN_LOG2 = led_map_pkg::PWM_WIN_LOG2
) (
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire logic I_CE,
   input wire led_map_pkg::reg_req_s I_REG_REQ,
   input wire logic I_PWM,
   output logic [7:0] O_REG_RDATA,
   output logic O_DEVICE_ENABLE,
   output logic O_SIMPLE_ENABLE,
   output led_map_pkg::ua_t O_LED_CURRENT_TARGET
);
   import led_map_pkg::*;

   gen_cfg_s cfg_q;
   logic [6:0] brightness_code_q;
   logic [WIN_LOG2-1:0] win_cnt_q;
   logic [WIN_LOG2:0] high_cnt_q;
   logic [WIN_LOG2:0] high_cnt_d;
   logic [DUTY_BITS:0] duty_q;
   logic pwm_active;
   pct_t pct_d;
   pct_t pct_q;
   ua_t full_scale_led_current_q;
   ua_t base_q;
   logic [24:0] lin_wide;
   logic [31:0] prod_d;
   logic [23:0] duty_prod_d;
   ua_t led_current_target_d;

   // Register writes
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         cfg_q <= gen_cfg_s'(GEN_CFG_RST);
      end
      else if (I_CE && I_REG_REQ.wr && I_REG_REQ.addr == GEN_CFG_ADDR)
      begin
         cfg_q <= gen_cfg_s'(I_REG_REQ.wdata);
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         brightness_code_q <= BRIGHT_RST;
      end
      else if (I_CE && I_REG_REQ.wr && I_REG_REQ.addr == BRIGHT_ADDR)
      begin
         // Top bit dropped: only 128 codes exist
         brightness_code_q <= I_REG_REQ.wdata[6:0];
      end
   end

   // Register reads, unmapped addresses read zero
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         O_REG_RDATA <= 8'h00;
      end
      else if (I_CE)
      begin
         if (I_REG_REQ.addr == GEN_CFG_ADDR)
         begin
            O_REG_RDATA <= 8'(cfg_q);
         end
         else if (I_REG_REQ.addr == BRIGHT_ADDR)
         begin
            O_REG_RDATA <= {1'b0, brightness_code_q};
         end
         else
         begin
            O_REG_RDATA <= 8'h00;
         end
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         O_DEVICE_ENABLE <= 1'b0;
         O_SIMPLE_ENABLE <= 1'b0;
      end
      else if (I_CE)
      begin
         O_DEVICE_ENABLE <= cfg_q.dev_en;
         O_SIMPLE_ENABLE <= cfg_q.simple_en;
      end
   end

   // Duty measured over a fixed power-of-two window so scaling is a shift
   assign pwm_active = I_PWM ^ cfg_q.pwm_neg;
   assign high_cnt_d = high_cnt_q + (WIN_LOG2 + 1)'(pwm_active);

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         win_cnt_q <= '0;
         high_cnt_q <= '0;
         duty_q <= '0;
      end
      else if (I_CE)
      begin
         win_cnt_q <= win_cnt_q + 1'b1;
         if (&win_cnt_q)
         begin
            duty_q <= high_cnt_d[WIN_LOG2 -: DUTY_BITS + 1];
            high_cnt_q <= '0;
         end
         else
         begin
            high_cnt_q <= high_cnt_d;
         end
      end
   end

   // Exponential table lookup or linear formula, no interpolation between codes
   assign lin_wide = 25'((25'(brightness_code_q) + 25'h1) * 25'(PCT_FULL)) >> LIN_SHIFT;

   always_comb
   begin
      if (!cfg_q.lin_map)
      begin
         pct_d = EXP_PCT[brightness_code_q];
      end
      else if (brightness_code_q == 7'h00)
      begin
         pct_d = '0;
      end
      else if (brightness_code_q == LIN_SPECIAL_CODE)
      begin
         pct_d = LIN_SPECIAL_PCT;
      end
      else
      begin
         pct_d = lin_wide[16:0];
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         pct_q <= '0;
         full_scale_led_current_q <= '0;
      end
      else if (I_CE)
      begin
         pct_q <= pct_d;
         full_scale_led_current_q <= FS_UA[cfg_q.fs_sel];
      end
   end

   assign prod_d = 32'(full_scale_led_current_q) * 32'(pct_q);

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         base_q <= '0;
      end
      else if (I_CE)
      begin
         base_q <= 15'(prod_d / 32'(PCT_FULL));
      end
   end

   assign duty_prod_d = 24'(base_q) * 24'(duty_q);

   // Disabled device forces zero; PWM off means duty is not looked at
   always_comb
   begin
      if (!cfg_q.dev_en)
      begin
         led_current_target_d = '0;
      end
      else if (cfg_q.pwm_en)
      begin
         led_current_target_d = duty_prod_d[DUTY_BITS +: 15];
      end
      else
      begin
         led_current_target_d = base_q;
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RESET)
      begin
         O_LED_CURRENT_TARGET <= '0;
      end
      else if (I_CE)
      begin
         O_LED_CURRENT_TARGET <= led_current_target_d;
      end
   end

   // Checks
   AST_SIMPLE: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE |=> O_SIMPLE_ENABLE == $past(cfg_q.simple_en))
      else $error("Simple enable output wrong");

   AST_POLARITY: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      !cfg_q.pwm_neg |-> pwm_active == I_PWM)
      else $error("Positive polarity not followed");

   AST_NEG_POL: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      cfg_q.pwm_neg |-> pwm_active == !I_PWM)
      else $error("Negative polarity not followed");

   AST_PWM_SCALE: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE && cfg_q.dev_en && cfg_q.pwm_en |=>
      O_LED_CURRENT_TARGET == 15'((24'($past(base_q)) * 24'($past(duty_q))) >> DUTY_BITS))
      else $error("Duty scaling wrong");

   AST_FULL_SCALE: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE && cfg_q.fs_sel == 3'h4 |=> full_scale_led_current_q == 15'h3C8C)
      else $error("Full scale 100 not 15.5 mA");

   AST_FULL_SCALE_5: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE && cfg_q.fs_sel == 3'h5 |=> full_scale_led_current_q == 15'h57E4)
      else $error("Full scale 101 not 22.5 mA");

   AST_DISABLE: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE && !cfg_q.dev_en |=> O_LED_CURRENT_TARGET == '0)
      else $error("Disabled device drives current");

   AST_NO_DUTY: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE && cfg_q.dev_en && !cfg_q.pwm_en |=> O_LED_CURRENT_TARGET == $past(base_q))
      else $error("Duty used with PWM off");

   AST_SERIAL_PRODUCT: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE |=> base_q == 15'((32'($past(full_scale_led_current_q)) * 32'($past(pct_q)))
      / 32'(PCT_FULL)))
      else $error("Product of full scale and percentage wrong");

   AST_EXP_LOW: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      !cfg_q.lin_map && brightness_code_q == 7'h01 |-> pct_d == 17'h00050)
      else $error("Exponential code 1 not 0.080 percent");

   AST_EXP_72: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      !cfg_q.lin_map && brightness_code_q == 7'h72 |-> pct_d == 17'h0BD36)
      else $error("Exponential code 0x72 wrong");

   AST_LIN_72: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      cfg_q.lin_map && brightness_code_q == 7'h72 |-> pct_d == 17'h15EA0)
      else $error("Linear code 0x72 wrong");

   AST_MAP_SWITCH: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE && $stable(brightness_code_q) && $changed(cfg_q.lin_map)
      && brightness_code_q == 7'h72 |-> pct_d != $past(pct_d))
      else $error("Mapping select had no effect");

   AST_CODE_ZERO: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      brightness_code_q == 7'h00 |-> pct_d == '0)
      else $error("Code zero not zero percent");

   AST_DEV_ENABLE: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE |=> O_DEVICE_ENABLE == $past(cfg_q.dev_en))
      else $error("Device enable output wrong");

   // Struct layout checked against the bit positions, not against itself
   AST_CFG_FLAGS: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE && I_REG_REQ.wr && I_REG_REQ.addr == GEN_CFG_ADDR |=>
      cfg_q.simple_en == $past(I_REG_REQ.wdata[SIMPLE_EN_BIT])
      && cfg_q.pwm_neg == $past(I_REG_REQ.wdata[PWM_NEG_BIT])
      && cfg_q.pwm_en == $past(I_REG_REQ.wdata[PWM_EN_BIT])
      && cfg_q.dev_en == $past(I_REG_REQ.wdata[DEV_EN_BIT]))
      else $error("Configuration flag bit misplaced");

   AST_CFG_FIELDS: assert property (@(posedge I_REF_CLK) disable iff (I_RESET)
      I_CE && I_REG_REQ.wr && I_REG_REQ.addr == GEN_CFG_ADDR |=>
      cfg_q.fs_sel == $past(I_REG_REQ.wdata[FS_LSB +: 3])
      && cfg_q.lin_map == $past(I_REG_REQ.wdata[LIN_MAP_BIT]))
      else $error("Full-scale or mapping field misplaced");

   COV_SERIAL: cover property (@(posedge I_REF_CLK) disable iff (I_RESET)
      cfg_q.dev_en && !cfg_q.pwm_en && !cfg_q.simple_en && O_LED_CURRENT_TARGET != '0);
   COV_PWM: cover property (@(posedge I_REF_CLK) disable iff (I_RESET)
      cfg_q.dev_en && cfg_q.pwm_en && duty_q != '0 && O_LED_CURRENT_TARGET != '0);
   COV_LINEAR: cover property (@(posedge I_REF_CLK) disable iff (I_RESET)
      cfg_q.lin_map && cfg_q.dev_en && pct_q == LIN_SPECIAL_PCT);
   COV_NEG_PWM: cover property (@(posedge I_REF_CLK) disable iff (I_RESET)
      cfg_q.pwm_neg && cfg_q.pwm_en && O_LED_CURRENT_TARGET != '0);
endmodule
`default_nettype wire

// *** pkg/led_map_pkg.sv ***
`default_nettype none
package led_map_pkg;
   typedef logic [16:0] pct_t;
   typedef logic [14:0] ua_t;
   typedef struct packed {
      logic simple_en;
      logic pwm_neg;
      logic pwm_en;
      logic [2:0] fs_sel;
      logic lin_map;
      logic dev_en;
   } gen_cfg_s;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;
   localparam logic [7:0] GEN_CFG_ADDR = 8'h10;
   localparam logic [7:0] BRIGHT_ADDR = 8'hA0;
   localparam logic [7:0] GEN_CFG_RST = 8'h00;
   localparam logic [6:0] BRIGHT_RST = 7'h00;
   localparam int SIMPLE_EN_BIT = 7;
   localparam int PWM_NEG_BIT = 6;
   localparam int PWM_EN_BIT = 5;
   localparam int FS_LSB = 2;
   localparam int LIN_MAP_BIT = 1;
   localparam int DEV_EN_BIT = 0;
   localparam int PCT_FULL = 100000;
   localparam logic [6:0] LIN_SPECIAL_CODE = 7'h72;
   localparam pct_t LIN_SPECIAL_PCT = 17'h15EA0;
   localparam int LIN_SHIFT = 7;
   localparam int DUTY_BITS = 8;
   localparam int PWM_WIN_LOG2 = 19;
   localparam ua_t FS_UA [8] = '{15'h1F40, 15'h2328, 15'h2710, 15'h2AF8,
                                 15'h3C8C, 15'h57E4, 15'h6590, 15'h7368};
   localparam pct_t EXP_PCT [128] = '{
      0, 80, 86, 94, 102, 109, 117, 125, 133, 141, 148, 156, 164, 172, 180, 188,
      203, 211, 227, 242, 250, 266, 281, 297, 320, 336, 352, 375, 398, 422, 445,
      469, 500, 523, 555, 586, 617, 656, 695, 734, 773, 820, 867, 914, 969, 1031,
      1078, 1148, 1219, 1281, 1359, 1430, 1523, 1594, 1688, 1781, 1898, 2016,
      2109, 2250, 2367, 2508, 2648, 2789, 2953, 3125, 3336, 3500, 3719, 3906,
      4141, 4375, 4648, 4922, 5195, 5469, 5781, 6125, 6484, 6875, 7266, 7656,
      8047, 8594, 9063, 9609, 10078, 10781, 11250, 11953, 12656, 13359, 14219,
      15000, 15859, 16875, 17813, 18750, 19922, 20859, 22266, 23438, 24844,
      26250, 27656, 29297, 31172, 32813, 34453, 35547, 38828, 41016, 43203,
      45938, 48438, 51406, 54141, 57031, 60703, 63984, 67813, 71875, 75781,
      79688, 84375, 89844, 94531, 100000};
endpackage
`default_nettype wire

// *** verif/pwm_wave_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host-side PWM source, period and high time in clock cycles
module pwm_wave_gen (
   input wire logic i_clk,
   input wire logic [7:0] i_period,
   input wire logic [7:0] i_high,
   output logic o_pwm
);
   logic [7:0] cnt_q = 8'h00;
   // Delayed update keeps the edge sample race free
   always @(posedge i_clk)
   begin
      cnt_q <= #1 ((cnt_q + 8'h01) >= i_period) ? 8'h00 : cnt_q + 8'h01;
   end
   assign o_pwm = (cnt_q < i_high);
endmodule
`default_nettype wire

// *** verif/led_brightness_code_mapper_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module led_brightness_code_mapper_bench;
   import led_map_pkg::*;
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] brightness_code;
      ua_t cur;
   } row_s;
   // Serial-only rows; PWM toggles meanwhile and must not matter
   localparam row_s ROWS [9] = '{
      '{8'h15, 8'h72, 15'h2A92}, '{8'h17, 8'h72, 15'h4EE4}, '{8'h17, 8'h40, 15'h2CA1},
      '{8'h11, 8'h73, 15'h1F1F}, '{8'h11, 8'h01, 15'h000C}, '{8'h15, 8'h00, 15'h0000},
      '{8'h15, 8'h7F, 15'h57E4}, '{8'h14, 8'h7F, 15'h0000}, '{8'h97, 8'h00, 15'h0000}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   reg_req_s req = '0;
   logic [7:0] per = 8'h40;
   logic [7:0] hi = 8'h20;
   logic pwm;
   logic [7:0] rdata;
   logic dev_en;
   logic simple_en;
   ua_t cur;
   int n_errors = 0;
   int tests_run = 0;
   always #4 clk = ~clk;
   led_brightness_code_mapper #(.WIN_LOG2(8)) u_dut (.I_REF_CLK(clk), .I_RESET(rst),
      .I_CE(ce), .I_REG_REQ(req), .I_PWM(pwm), .O_REG_RDATA(rdata),
      .O_DEVICE_ENABLE(dev_en), .O_SIMPLE_ENABLE(simple_en), .O_LED_CURRENT_TARGET(cur));
   pwm_wave_gen u_pwm (.i_clk(clk), .i_period(per), .i_high(hi), .o_pwm(pwm));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk_ua(input ua_t got, input ua_t exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask
   // Extra idle cycle so the strobe is never raised in the step it fell
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      req = '{1'b1, a, d};
      tick(1);
      req.wr = 1'b0;
      tick(1);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      req.addr = a;
      tick(1);
      chk8(rdata, e, "read data");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_errors++;
      $display("mismatch at %0t: run timed out", $time);
      report_and_stop;
   end
   initial
   begin
      tick(16);
      rst = 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         wr_reg(GEN_CFG_ADDR, ROWS[i].cfg);
         wr_reg(BRIGHT_ADDR, ROWS[i].brightness_code);
         tick(8);
         chk_ua(cur, ROWS[i].cur, "current");
         chk8({6'h00, simple_en, dev_en}, {6'h00, ROWS[i].cfg[7], ROWS[i].cfg[0]}, "flags");
         rd_chk(GEN_CFG_ADDR, ROWS[i].cfg);
         $display("row %0d done", i);
      end
      wr_reg(BRIGHT_ADDR, 8'hF2);
      rd_chk(BRIGHT_ADDR, 8'h72);
      wr_reg(8'h11, 8'hFF);
      rd_chk(8'h11, 8'h00);
      rd_chk(GEN_CFG_ADDR, 8'h97);
      ce = 1'b0;
      wr_reg(GEN_CFG_ADDR, 8'h00);
      ce = 1'b1;
      rd_chk(GEN_CFG_ADDR, 8'h97);
      $display("register map test done");
      // 48 of 64 high: three quarters duty, 256-cycle window holds whole periods
      hi = 8'h30;
      // Bits 4:2 = 100 for 15.5 mA full scale, PWM on, positive polarity
      wr_reg(GEN_CFG_ADDR, 8'h31);
      wr_reg(BRIGHT_ADDR, 8'h73);
      tick(800);
      chk_ua(cur, 15'h1757, "pwm positive");
      wr_reg(GEN_CFG_ADDR, 8'h71);
      tick(800);
      chk_ua(cur, 15'h07C7, "pwm negative");
      $display("pwm test done");
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      chk_ua(cur, 15'h0000, "reset current");
      chk8({6'h00, simple_en, dev_en}, 8'h00, "reset flags");
      rd_chk(GEN_CFG_ADDR, GEN_CFG_RST);
      rd_chk(BRIGHT_ADDR, {1'b0, BRIGHT_RST});
      $display("reset test done");
      report_and_stop;
   end
endmodule
`default_nettype wire
